/* File: suer_pkg.sv */
// suer_pkg: constants for the special-unit error and restart block
// assumes one 250 MHz clock and an apb register bus
package suer_pkg;
  localparam int SUER_UNITS = 10;
  localparam int SUER_NUM_W = 4;
  localparam int SUER_WORDS_PER_UNIT = 10;
  localparam int SUER_REFRESH_BASE = 100;
  // register byte offsets
  localparam logic [7:0] SUER_OFS_ERR = 8'h00;
  localparam logic [7:0] SUER_OFS_RST = 8'h04;
  localparam logic [7:0] SUER_OFS_SUM = 8'h08;
  localparam logic [7:0] SUER_OFS_IRQ_ST = 8'h0C;
  localparam logic [7:0] SUER_OFS_IRQ_EN = 8'h10;
  localparam logic [7:0] SUER_OFS_IRQ_CLR = 8'h14;
  localparam logic [7:0] SUER_OFS_STATE = 8'h18;
  // summary register fields
  localparam int SUER_SUM_BIT = 0;
  localparam int SUER_HALT_BIT = 1;
  localparam int SUER_WAIT_BIT = 2;
  // interrupt status fields
  localparam int SUER_IRQ_DUP = 0;
  localparam int SUER_IRQ_REFR = 1;
  localparam int SUER_IRQ_DEFECT = 2;
  localparam int SUER_IRQ_RESTART = 3;
  localparam int SUER_IRQ_W = 4;
  // reset values
  localparam logic [9:0] SUER_RST_FLAGS = 10'h000;
  localparam logic [SUER_IRQ_W-1:0] SUER_RST_IRQ = 4'h0;
  typedef enum logic [1:0] {
    SUER_RUN = 2'b00,
    SUER_HALT = 2'b01,
    SUER_WAIT = 2'b10
  } suer_state_t;
endpackage : suer_pkg

/* File: suer_restart_det.sv */
// suer_restart_det: off-on-off detector for one restart bit
// assumes the bit is a register in the same clock domain
`timescale 1ns/10ps
`default_nettype none
module suer_restart_det (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // restart bit and completion pulse
  input wire logic restart_bit,
  output logic restart_done
);
  logic armed;
  logic last;
  wire rise = restart_bit & ~last;
  wire fall = ~restart_bit & last;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      last <= 1'b0;
      armed <= 1'b0;
    end else begin
      last <= restart_bit;
      if (rise) begin
        armed <= 1'b1;
      end else if (fall) begin
        armed <= 1'b0;
      end
    end
  end
  assign restart_done = fall & armed;
endmodule : suer_restart_det
`default_nettype wire

/* File: suer_top.sv */
// suer_top: special-unit error flags, summary bit and restart bits
// assumes an apb master on sys_clk and units on the expansion bus
`timescale 1ns/10ps
`default_nettype none
module suer_top
  import suer_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // special units, slot i holds the unit in position i
  input wire logic [SUER_UNITS*SUER_NUM_W-1:0] unit_switch_num,
  input wire logic [SUER_UNITS-1:0] unit_present,
  input wire logic [SUER_UNITS-1:0] unit_defective,
  input wire logic [SUER_UNITS-1:0] refresh_fault,
  // controller side
  output logic [SUER_UNITS-1:0] unit_reinit,
  output logic [SUER_UNITS-1:0] unit_refresh_en,
  output logic [SUER_UNITS*SUER_NUM_W-1:0] unit_live_num,
  output logic [SUER_UNITS*8-1:0] unit_refresh_base,
  output logic program_halt,
  output logic cpu_waiting,
  output logic [SUER_UNITS-1:0] io_table_unknown,
  output logic irq
);
  // ==========================================================
  // reset release
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================================
  // registers
  logic [SUER_UNITS-1:0] unit_error_flags;
  logic [SUER_UNITS-1:0] unit_restart_bits;
  logic special_unit_error_summary;
  logic [SUER_IRQ_W-1:0] irq_status;
  logic [SUER_IRQ_W-1:0] irq_enable;
  suer_state_t state;
  suer_state_t next_state;

  // ==========================================================
  // per-unit slots
  logic [SUER_UNITS-1:0] restart_done;
  logic [SUER_UNITS-1:0] stopped;
  logic [SUER_UNITS-1:0] dup_hit;
  logic [SUER_UNITS-1:0] refr_hit;
  logic [SUER_UNITS-1:0] defect_hit;
  logic [SUER_NUM_W-1:0] live [SUER_UNITS];

  // numbers are latched on the first edge after reset; until then every
  // live copy reads zero and would look like one big duplicate
  logic nums_valid;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nums_valid <= 1'b0;
    end else begin
      nums_valid <= 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < SUER_UNITS; gi++) begin : g_unit
      logic [SUER_UNITS-1:0] same;
      genvar gj;
      suer_restart_det u_det (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .restart_bit(unit_restart_bits[gi]),
        .restart_done(restart_done[gi])
      );
      suer_unit_slot u_slot (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .switch_num(unit_switch_num[gi*SUER_NUM_W +: SUER_NUM_W]),
        .restart_done(restart_done[gi]),
        .refresh_fault(refresh_fault[gi] & unit_present[gi]),
        .live_num(live[gi]),
        .stopped(stopped[gi])
      );
      for (gj = 0; gj < SUER_UNITS; gj++) begin : g_cmp
        assign same[gj] = (gj != gi) && unit_present[gj]
          && (live[gj] == live[gi]);
      end
      // flag lands on the duplicated number
      assign dup_hit[gi] = nums_valid && unit_present[gi] && (|same);
      assign refr_hit[gi] = nums_valid & unit_present[gi]
        & refresh_fault[gi];
      assign defect_hit[gi] = unit_present[gi] & unit_defective[gi];
      assign unit_live_num[gi*SUER_NUM_W +: SUER_NUM_W] = live[gi];
      // ten refresh words per unit number
      assign unit_refresh_base[gi*8 +: 8] = 8'(SUER_REFRESH_BASE
        + SUER_WORDS_PER_UNIT * int'(live[gi]));
    end
  endgenerate

  // map per-slot hits onto unit-number flag positions
  logic [SUER_UNITS-1:0] set_by_num;
  always_comb begin
    set_by_num = '0;
    for (int k = 0; k < SUER_UNITS; k++) begin
      if ((dup_hit[k] || refr_hit[k]) && live[k] < SUER_UNITS) begin
        set_by_num[live[k]] = 1'b1;
      end
    end
  end

  // restart of a flag bit position clears that number's flag
  logic [SUER_UNITS-1:0] clr_by_num;
  assign clr_by_num = restart_done;

  wire any_dup = |dup_hit;
  wire any_refr = |refr_hit;
  wire any_defect = |defect_hit;

  // ==========================================================
  // apb decode
  wire apb_acc = psel & penable;
  wire apb_wr = apb_acc & pwrite;
  wire hit_err = (paddr == SUER_OFS_ERR);
  wire hit_rst = (paddr == SUER_OFS_RST);
  wire hit_sum = (paddr == SUER_OFS_SUM);
  wire hit_ist = (paddr == SUER_OFS_IRQ_ST);
  wire hit_ien = (paddr == SUER_OFS_IRQ_EN);
  wire hit_icl = (paddr == SUER_OFS_IRQ_CLR);
  wire hit_sta = (paddr == SUER_OFS_STATE);
  wire hit_any = hit_err | hit_rst | hit_sum | hit_ist | hit_ien
    | hit_icl | hit_sta;
  wire wr_rst = apb_wr & hit_rst;
  wire wr_ien = apb_wr & hit_ien;
  wire wr_icl = apb_wr & hit_icl;
  // read-only registers refuse writes, unmapped refuses all
  wire bad = ~hit_any | (pwrite & (hit_err | hit_sum | hit_ist
    | hit_sta));

  assign pready = 1'b1;
  assign pslverr = apb_acc & bad;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_err) rd_mux[SUER_UNITS-1:0] = unit_error_flags;
    if (hit_rst) rd_mux[SUER_UNITS-1:0] = unit_restart_bits;
    if (hit_sum) begin
      rd_mux[SUER_SUM_BIT] = special_unit_error_summary;
      rd_mux[SUER_HALT_BIT] = program_halt;
      rd_mux[SUER_WAIT_BIT] = cpu_waiting;
    end
    if (hit_ist) rd_mux[SUER_IRQ_W-1:0] = irq_status;
    if (hit_ien) rd_mux[SUER_IRQ_W-1:0] = irq_enable;
    if (hit_sta) rd_mux[1:0] = state;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ==========================================================
  // error flags and summary
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_error_flags <= SUER_RST_FLAGS;
      unit_restart_bits <= SUER_RST_FLAGS;
      special_unit_error_summary <= 1'b0;
    end else begin
      if (wr_rst) begin
        unit_restart_bits <= pwdata[SUER_UNITS-1:0];
      end
      // set wins over the restart clear
      unit_error_flags <= (unit_error_flags & ~clr_by_num)
        | set_by_num;
      if (any_dup || any_refr) begin
        special_unit_error_summary <= 1'b1;
      end else if (~|(unit_error_flags & ~clr_by_num)) begin
        special_unit_error_summary <= 1'b0;
      end
    end
  end

  // ==========================================================
  // controller run state
  always_comb begin
    case (state)
      SUER_RUN: begin
        if (any_dup) next_state = SUER_HALT;
        else if (any_defect) next_state = SUER_WAIT;
        else next_state = SUER_RUN;
      end
      SUER_HALT: begin
        if (any_dup) next_state = SUER_HALT;
        else next_state = any_defect ? SUER_WAIT : SUER_RUN;
      end
      SUER_WAIT: begin
        if (any_dup) next_state = SUER_HALT;
        else next_state = any_defect ? SUER_WAIT : SUER_RUN;
      end
      default: next_state = SUER_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SUER_RUN;
    end else begin
      state <= next_state;
    end
  end

  // duplicate halts; refresh fault does not
  assign program_halt = (state == SUER_HALT);
  // defective unit: waiting, table shows unknown
  assign cpu_waiting = (state == SUER_WAIT);
  assign io_table_unknown = defect_hit;
  assign unit_refresh_en = unit_present & ~stopped
    & {SUER_UNITS{~program_halt}};
  assign unit_reinit = restart_done;

  // ==========================================================
  // interrupts
  logic [SUER_IRQ_W-1:0] irq_ev;
  assign irq_ev = {|restart_done, any_defect, any_refr, any_dup};
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= SUER_RST_IRQ;
      irq_enable <= SUER_RST_IRQ;
    end else begin
      irq_status <= (irq_status & ~({SUER_IRQ_W{wr_icl}}
        & pwdata[SUER_IRQ_W-1:0])) | irq_ev;
      if (wr_ien) irq_enable <= pwdata[SUER_IRQ_W-1:0];
    end
  end
  assign irq = |(irq_status & irq_enable);

  // ==========================================================
  // checks
  // duplicate leads to summary and halt next cycle
  a_dup_halts: assert property (@(posedge sys_clk) disable iff (!rst_n)
    any_dup |=> special_unit_error_summary && program_halt)
    else $error("duplicate number did not halt");
  // refresh fault alone keeps program running
  a_refr_runs: assert property (@(posedge sys_clk) disable iff (!rst_n)
    any_refr && !any_dup && state == SUER_RUN && !any_defect
    |=> special_unit_error_summary && !program_halt)
    else $error("refresh fault halted program");
  // faulty slot is not refreshed afterwards
  a_fault_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    refr_hit[3] && !restart_done[3] |=> !unit_refresh_en[3])
    else $error("faulty unit still refreshed");
  // flag of the unit number sets
  a_flag_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
    refr_hit[3] && live[3] == 4'h3 |=> unit_error_flags[3])
    else $error("error flag not set");
  // helper: cycles for which restart bit 3 has stood on, saturating,
  // so the on phase may last any number of cycles
  logic [3:0] hold3;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold3 <= 4'h0;
    end else if (!unit_restart_bits[3]) begin
      hold3 <= 4'h0;
    end else if (hold3 != 4'hF) begin
      hold3 <= hold3 + 4'h1;
    end
  end
  sequence s_rise3;
    !unit_restart_bits[3] ##1 unit_restart_bits[3];
  endsequence
  sequence s_fall3;
    unit_restart_bits[3] ##1 !unit_restart_bits[3];
  endsequence
  // off-on-off yields reinit in the cycle the bit is off again
  a_restart_seq: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_fall3 ##0 (hold3 != 4'h0) |-> unit_reinit[3])
    else $error("restart sequence gave no reinit");
  // switching the bit on alone does not restart
  a_rise_noinit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_rise3 |-> !unit_reinit[3])
    else $error("restart bit rise gave reinit");
  // restart clears the flag when no new error
  a_restart_clr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    restart_done[3] && !set_by_num[3] |=> !unit_error_flags[3])
    else $error("restart did not clear flag");
  // restart lifts the stop when no fault stands
  a_stop_lifts: assert property (@(posedge sys_clk) disable iff (!rst_n)
    restart_done[3] && !refresh_fault[3] |=> !stopped[3])
    else $error("restart left unit stopped");
  a_reinit_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    unit_reinit[3] |=> !unit_reinit[3])
    else $error("reinit pulse too long");
  a_defect_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
    any_defect && !any_dup |=> cpu_waiting)
    else $error("defective unit not waiting");
  // waiting only follows a defective unit
  a_wait_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cpu_waiting |-> $past(any_defect))
    else $error("waiting without defective unit");
  a_halt_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    program_halt |-> $past(any_dup))
    else $error("halt without duplicate");
  // a halted program refreshes no unit
  a_halt_norefr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    program_halt |-> unit_refresh_en == '0)
    else $error("unit refreshed while halted");
  a_num_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n) && !restart_done[5] |=> $stable(live[5]))
    else $error("unit number changed without restart");
endmodule : suer_top
`default_nettype wire

/* File: suer_top_tb.sv */
// suer_top_tb: self-checking bench for the error and restart block
// assumes suer_unit_model stands in for the special units
`timescale 1ns/10ps
`default_nettype none
module suer_top_tb;
  import suer_pkg::*;
  logic sys_clk = 1'h0;
  logic rst_b = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, program_halt, cpu_waiting, irq;
  logic [SUER_UNITS*SUER_NUM_W-1:0] set_num, sw, live;
  logic [SUER_UNITS-1:0] set_def = '0, set_fault = '0, pres, defv, flt;
  logic [SUER_UNITS-1:0] reinit, ren, unk;
  logic [SUER_UNITS*8-1:0] base;
  int fails = 0, compares = 0, hits = 0, ck = 0;
  // ==========================================
  // clock, design and unit model
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  suer_top dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .unit_switch_num(sw),
    .unit_present(pres), .unit_defective(defv), .refresh_fault(flt),
    .unit_reinit(reinit), .unit_refresh_en(ren), .unit_live_num(live),
    .unit_refresh_base(base), .program_halt(program_halt),
    .cpu_waiting(cpu_waiting), .io_table_unknown(unk), .irq(irq)
  );
  suer_unit_model model_u (
    .sys_clk(sys_clk), .set_num(set_num), .set_def(set_def),
    .set_fault(set_fault), .unit_switch_num(sw), .unit_present(pres),
    .unit_defective(defv), .refresh_fault(flt)
  );
  // counting cycles with reinit high catches a reinit that lasts too long
  always @(posedge sys_clk) begin
    if (reinit[ck] === 1'h1) begin
      hits <= hits + 1;
    end
  end
  // ==========================================
  // shared tasks
  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin
      fails++;
      end_of_test();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  task automatic do_reset();
    rst_b <= 1'h0;
    tick(8);
    rst_b <= 1'h1;
    tick(4);
  endtask : do_reset
  task automatic restart(input int i);
    int h0;
    ck = i;
    h0 = hits;
    apb(1'h1, SUER_OFS_RST, 32'h1 << i);
    apb(1'h1, SUER_OFS_RST, 32'h0);
    tick(4);
    chk(32'(hits - h0), 32'h1);
  endtask : restart
  // ==========================================
  // scenarios
  task automatic t_reset_values();
    rdchk(SUER_OFS_ERR, {22'h0, SUER_RST_FLAGS});
    rdchk(SUER_OFS_RST, 32'h0);
    rdchk(SUER_OFS_SUM, 32'h0);
    for (int i = 0; i < SUER_UNITS; i++) begin
      chk({24'h0, base[8*i+:8]}, 32'(SUER_REFRESH_BASE + 10*i));
    end
    chk({22'h0, ren}, 32'h3FF);
    rdchk(8'h1C, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'h1, SUER_OFS_ERR, 32'h3FF);
    chk({31'h0, err}, 32'h1);
    rdchk(SUER_OFS_ERR, 32'h0);
  endtask : t_reset_values
  task automatic t_refresh_fault();
    apb(1'h1, SUER_OFS_IRQ_EN, 32'h2);
    set_fault[3] <= 1'h1;
    tick(1);
    set_fault[3] <= 1'h0;
    tick(4);
    chk({22'h0, ren}, 32'h3F7);
    chk({31'h0, program_halt}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rdchk(SUER_OFS_ERR, 32'h8);
    rdchk(SUER_OFS_SUM, 32'h1);
    apb(1'h1, SUER_OFS_IRQ_EN, 32'h0);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    apb(1'h1, SUER_OFS_IRQ_CLR, 32'h2);
    apb(1'h1, SUER_OFS_IRQ_EN, 32'h2);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    restart(3);
    chk({22'h0, ren}, 32'h3FF);
    rdchk(SUER_OFS_ERR, 32'h0);
    rdchk(SUER_OFS_SUM, 32'h0);
    rdchk(SUER_OFS_IRQ_ST, 32'h8);
  endtask : t_refresh_fault
  task automatic t_duplicate();
    set_num[20+:4] <= 4'h2;
    tick(4);
    chk({28'h0, live[20+:4]}, 32'h5);
    chk({31'h0, program_halt}, 32'h0);
    restart(5);
    chk({28'h0, live[20+:4]}, 32'h2);
    chk({31'h0, program_halt}, 32'h1);
    chk({22'h0, ren}, 32'h0);
    rdchk(SUER_OFS_ERR, 32'h4);
    rdchk(SUER_OFS_SUM, 32'h3);
    rdchk(SUER_OFS_STATE, 32'h1);
    set_num[20+:4] <= 4'h5;
    do_reset();
    chk({31'h0, program_halt}, 32'h0);
    chk({28'h0, live[20+:4]}, 32'h5);
    rdchk(SUER_OFS_ERR, 32'h0);
  endtask : t_duplicate
  task automatic t_defective();
    set_def[7] <= 1'h1;
    tick(4);
    chk({31'h0, cpu_waiting}, 32'h1);
    chk({22'h0, unk}, 32'h80);
    rdchk(SUER_OFS_SUM, 32'h4);
    rdchk(SUER_OFS_STATE, 32'h2);
  endtask : t_defective
  initial begin
    for (int i = 0; i < SUER_UNITS; i++) begin
      set_num[4*i+:4] = 4'(i);
    end
    do_reset();
    t_reset_values();
    t_refresh_fault();
    t_duplicate();
    t_defective();
    end_of_test();
  end
endmodule : suer_top_tb
`default_nettype wire

/* File: suer_unit_model.sv */
// suer_unit_model: special units sitting on the expansion bus
// assumes the bench turns switches and pulses faults on sys_clk
`timescale 1ns/10ps
`default_nettype none
module suer_unit_model
  import suer_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // bench controls
  input wire logic [SUER_UNITS*SUER_NUM_W-1:0] set_num,
  input wire logic [SUER_UNITS-1:0] set_def,
  input wire logic [SUER_UNITS-1:0] set_fault,
  // unit pins
  output logic [SUER_UNITS*SUER_NUM_W-1:0] unit_switch_num,
  output logic [SUER_UNITS-1:0] unit_present,
  output logic [SUER_UNITS-1:0] unit_defective,
  output logic [SUER_UNITS-1:0] refresh_fault
);
  initial begin
    unit_switch_num = set_num;
    unit_present = '1;
    unit_defective = '0;
    refresh_fault = '0;
  end
  // switch moves even with power on
  always @(posedge sys_clk) begin
    unit_switch_num <= set_num;
    unit_defective <= set_def;
    refresh_fault <= set_fault;
  end
endmodule : suer_unit_model
`default_nettype wire

/* File: suer_unit_slot.sv */
// suer_unit_slot: per-unit number latch and service state
// assumes unit number and present inputs are synchronous
`timescale 1ns/10ps
`default_nettype none
module suer_unit_slot
  import suer_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // unit side
  input wire logic [SUER_NUM_W-1:0] switch_num,
  input wire logic restart_done,
  input wire logic refresh_fault,
  // results
  output logic [SUER_NUM_W-1:0] live_num,
  output logic stopped
);
  logic loaded;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      live_num <= '0;
      loaded <= 1'b0;
      stopped <= 1'b0;
    end else begin
      // number only taken at power-up or restart
      // power-up load acts like a restart
      if (!loaded || restart_done) begin
        live_num <= switch_num;
        loaded <= 1'b1;
      end
      if (refresh_fault) begin
        stopped <= 1'b1;
      end else if (restart_done) begin
        stopped <= 1'b0;
      end
    end
  end
endmodule : suer_unit_slot
`default_nettype wire
